//--- rtl/lcd_pkg.sv
// Functional notes
// - Display on/off bit 0; off holds all column outputs low; the row scan keeps running.
// - Start line loads six bits; that memory line shows on top row.
// - Page pointer four bits; pages 0-7 full bytes, page 8 only bit 0.
// - Column pointer set by high-nibble (0001) and low-nibble (0000) opcodes.
// - Data access advances column by one; read advance stops at column 83h.
// - Data writes wrap the column to zero after the last column.
// - Status read returns mirror bit 6, display bit 5, reset bit 4, others zero.
// - Status display bit reads zero when on, one when off.
// - Status reset bit reads one while a reset is in progress.
// - No status or data reads in serial mode; host must not try.
// - Data write stores the byte at current page and column.
// - Data read returns the byte at current page and column.
// - Mirror flag reverses memory column order onto the column outputs.
// - Inverse flag swaps column drive levels; memory stays untouched.
// - All-pixels flag drives every column selected while display is on; clearing restores normal.
// - Bias bit selects drive bias ratio; output to the bias generator.
// - Read-modify-write: reads hold column, writes advance, until end opcode.
// - Other commands still execute during read-modify-write; all but software reset do so without leaving it.
// - End opcode leaves the mode and restores the column saved at entry.
// - Software reset restores start line, column and page pointers to defaults.
`default_nettype none

package lcd_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int COLUMN_COUNT = 132;
    localparam int PAGE_COUNT = 9;
    localparam int MEM_DEPTH = PAGE_COUNT * COLUMN_COUNT;
    localparam logic [3:0] ICON_PAGE = 4'h8;
    localparam logic [7:0] LAST_COLUMN = 8'h83;
    localparam logic [7:0] ICON_MASK = 8'h01;

    // ****************************************
    // Command opcodes and match masks
    // ****************************************
    localparam logic [7:0] MASK_FLAG = 8'hFE;
    localparam logic [7:0] MASK_NIBBLE = 8'hF0;
    localparam logic [7:0] MASK_LINE = 8'hC0;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] OPC_DISPLAY = 8'hAE;
    localparam logic [7:0] OPC_START_LINE = 8'h40;
    localparam logic [7:0] OPC_PAGE = 8'hB0;
    localparam logic [7:0] OPC_COLUMN_HIGH = 8'h10;
    localparam logic [7:0] OPC_COLUMN_LOW = 8'h00;
    localparam logic [7:0] OPC_MIRROR = 8'hA0;
    localparam logic [7:0] OPC_BIAS = 8'hA2;
    localparam logic [7:0] OPC_ALL_PIXELS = 8'hA4;
    localparam logic [7:0] OPC_INVERSE = 8'hA6;
    localparam logic [7:0] OPC_RMW = 8'hE0;
    localparam logic [7:0] OPC_END = 8'hEE;
    localparam logic [7:0] OPC_SOFT_RESET = 8'hE2;
    localparam logic [7:0] OPC_VOLUME_PREFIX = 8'h81;
    localparam logic [7:0] OPC_BOOSTER_PREFIX = 8'hF8;

    // ****************************************
    // Status byte fields
    // ****************************************
    localparam int STATUS_MIRROR_BIT = 6;
    localparam int STATUS_DISPLAY_BIT = 5;
    localparam int STATUS_RESET_BIT = 4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [5:0] START_LINE_RESET = 6'h00;
    localparam logic [7:0] COLUMN_RESET = 8'h00;
    localparam logic [3:0] PAGE_RESET = 4'h0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [5:0] ROW_RESET = 6'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SOFT_RESET_TIME_NS = 20;
    localparam int SOFT_RESET_CYCLES =
        (SOFT_RESET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [3:0] BUSY_COUNT_RESET = 4'(SOFT_RESET_CYCLES);

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [0:0] {
        LCD_ARG_IDLE = 1'b0,
        LCD_ARG_SKIP = 1'b1
    } lcd_arg_state_type;

endpackage

`default_nettype wire

//--- rtl/lcd_display_memory.sv
`default_nettype none

module lcd_display_memory (
    // Clock
    input wire logic clock_i,
    input wire logic enable_i,
    // Host port
    input wire logic write_en_i,
    input wire logic [3:0] page_i,
    input wire logic [7:0] column_i,
    input wire logic [7:0] write_data_i,
    output logic [7:0] read_data_o,
    // Scan port
    input wire logic [2:0] scan_page_i,
    input wire logic [2:0] scan_bit_i,
    output logic [lcd_pkg::COLUMN_COUNT-1:0] scan_bits_o
);
    import lcd_pkg::*;

    logic [7:0] mem_reg [MEM_DEPTH];
    logic [10:0] host_index;
    logic host_in_range;
    logic [7:0] store_data;

    assign host_index = 11'(page_i) * 11'(COLUMN_COUNT) + 11'(column_i);
    assign host_in_range = (page_i <= ICON_PAGE) && (column_i <= LAST_COLUMN);
    // Icon page keeps only bit 0 so that reads show zeros above it
    assign store_data = (page_i == ICON_PAGE) ? (write_data_i & ICON_MASK) : write_data_i;
    assign read_data_o = host_in_range ? mem_reg[host_index] : 8'h00;

    always_ff @(posedge clock_i) begin
        if (enable_i && write_en_i && host_in_range) begin
            mem_reg[host_index] <= store_data;
        end
    end

    genvar col;
    generate
        for (col = 0; col < COLUMN_COUNT; col++) begin : g_scan
            logic [10:0] scan_index;
            logic [7:0] scan_byte;
            assign scan_index = 11'(scan_page_i) * 11'(COLUMN_COUNT) + 11'(col);
            assign scan_byte = mem_reg[scan_index];
            assign scan_bits_o[col] = scan_byte[scan_bit_i];
        end
    endgenerate

endmodule

`default_nettype wire

//--- rtl/lcd_column_pixel.sv
`default_nettype none

module lcd_column_pixel (
    // Inputs
    input wire logic pixel_i,
    input wire logic negative_image_flag_i,
    input wire logic all_pixels_force_i,
    input wire logic display_on_i,
    // Output
    output logic level_o
);
    // Display off wins over forcing, forcing wins over inversion
    assign level_o = display_on_i &
        (all_pixels_force_i | (pixel_i ^ negative_image_flag_i));

endmodule

`default_nettype wire

//--- rtl/lcd_command_decoder.sv
`default_nettype none

module lcd_command_decoder (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    // Host byte port
    input wire logic bus_strobe_i,
    input wire logic command_data_select_i,
    input wire logic read_write_select_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic serial_mode_i,
    output logic [7:0] bus_rdata_o,
    output logic bus_rdata_valid_o,
    // Panel drive
    output logic [lcd_pkg::COLUMN_COUNT-1:0] column_driver_outputs_o,
    output logic [5:0] active_row_o,
    output logic display_on_o,
    output logic bias_ratio_bit_o
);
    import lcd_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic serial_meta_reg;
    logic serial_sync_reg;
    logic display_on_reg;
    logic column_mirror_flag_reg;
    logic negative_image_flag_reg;
    logic all_pixels_force_reg;
    logic bias_ratio_bit_reg;
    logic rmw_reg;
    logic [5:0] start_line_value_reg;
    logic [3:0] page_reg;
    logic [7:0] column_reg;
    logic [7:0] column_next;
    logic [7:0] saved_column_reg;
    logic [3:0] busy_count_reg;
    logic [5:0] row_reg;
    logic [7:0] rdata_reg;
    logic rdata_valid_reg;
    logic [COLUMN_COUNT-1:0] columns_reg;
    logic [5:0] row_out_reg;
    lcd_arg_state_type arg_state_reg;

    // ****************************************
    // Byte classification
    // ****************************************
    logic strobe_live;
    logic cmd_byte;
    logic cmd_write;
    logic data_write;
    logic status_read;
    logic data_read;
    logic [7:0] cmd;

    assign cmd = bus_wdata_i;
    assign strobe_live = enable_i && bus_strobe_i;
    assign cmd_byte = strobe_live && !command_data_select_i && !read_write_select_i;
    // The argument byte of a two-byte power command must not alias a column opcode
    assign cmd_write = cmd_byte && (arg_state_reg == LCD_ARG_IDLE);
    assign data_write = strobe_live && command_data_select_i && !read_write_select_i;
    assign status_read = strobe_live && !command_data_select_i && read_write_select_i &&
        !serial_sync_reg;
    assign data_read = strobe_live && command_data_select_i && read_write_select_i &&
        !serial_sync_reg;

    logic is_display;
    logic is_start;
    logic is_page;
    logic is_col_high;
    logic is_col_low;
    logic is_mirror;
    logic is_bias;
    logic is_all_pixels;
    logic is_inverse;
    logic is_rmw;
    logic is_end;
    logic is_soft_reset;
    logic is_prefix;

    assign is_display = cmd_write && ((cmd & MASK_FLAG) == OPC_DISPLAY);
    assign is_start = cmd_write && ((cmd & MASK_LINE) == OPC_START_LINE);
    assign is_page = cmd_write && ((cmd & MASK_NIBBLE) == OPC_PAGE);
    assign is_col_high = cmd_write && ((cmd & MASK_NIBBLE) == OPC_COLUMN_HIGH);
    assign is_col_low = cmd_write && ((cmd & MASK_NIBBLE) == OPC_COLUMN_LOW);
    assign is_mirror = cmd_write && ((cmd & MASK_FLAG) == OPC_MIRROR);
    assign is_bias = cmd_write && ((cmd & MASK_FLAG) == OPC_BIAS);
    assign is_all_pixels = cmd_write && ((cmd & MASK_FLAG) == OPC_ALL_PIXELS);
    assign is_inverse = cmd_write && ((cmd & MASK_FLAG) == OPC_INVERSE);
    assign is_rmw = cmd_write && ((cmd & MASK_FULL) == OPC_RMW);
    assign is_end = cmd_write && ((cmd & MASK_FULL) == OPC_END);
    assign is_soft_reset = cmd_write && ((cmd & MASK_FULL) == OPC_SOFT_RESET);
    assign is_prefix = cmd_write &&
        ((cmd == OPC_VOLUME_PREFIX) || (cmd == OPC_BOOSTER_PREFIX));

    // ****************************************
    // Column pointer
    // ****************************************
    logic column_at_end;
    logic [7:0] column_plus;

    assign column_at_end = (column_reg >= LAST_COLUMN);
    assign column_plus = 8'(column_reg + 8'h01);

    always_comb begin
        column_next = column_reg;
        if (is_soft_reset) begin
            column_next = COLUMN_RESET;
        end else if (is_end && rmw_reg) begin
            column_next = saved_column_reg;
        end else if (is_col_high) begin
            column_next = {cmd[3:0], column_reg[3:0]};
        end else if (is_col_low) begin
            column_next = {column_reg[7:4], cmd[3:0]};
        end else if (data_write) begin
            column_next = column_at_end ? COLUMN_RESET : column_plus;
        end else if (data_read && !rmw_reg) begin
            column_next = column_at_end ? column_reg : column_plus;
        end
    end

    // ****************************************
    // Status byte
    // ****************************************
    logic [7:0] status_byte;
    logic busy;

    assign busy = (busy_count_reg != 4'h0);

    always_comb begin
        status_byte = 8'h00;
        status_byte[STATUS_MIRROR_BIT] = column_mirror_flag_reg;
        status_byte[STATUS_DISPLAY_BIT] = !display_on_reg;
        status_byte[STATUS_RESET_BIT] = busy;
    end

    // ****************************************
    // Memory and scan
    // ****************************************
    logic [7:0] mem_read_data;
    logic [COLUMN_COUNT-1:0] scan_bits;
    logic [COLUMN_COUNT-1:0] column_levels;
    logic [5:0] scan_line;

    // Top panel row shows the start line; following rows wrap within 64 lines
    assign scan_line = 6'(start_line_value_reg + row_reg);

    lcd_display_memory u_memory (
        .clock_i(clock_i),
        .enable_i(enable_i),
        .write_en_i(data_write),
        .page_i(page_reg),
        .column_i(column_reg),
        .write_data_i(bus_wdata_i),
        .read_data_o(mem_read_data),
        .scan_page_i(scan_line[5:3]),
        .scan_bit_i(scan_line[2:0]),
        .scan_bits_o(scan_bits)
    );

    genvar column_driver_outputs;
    generate
        for (column_driver_outputs = 0; column_driver_outputs < COLUMN_COUNT; column_driver_outputs++) begin : g_column
            logic pixel;
            assign pixel = column_mirror_flag_reg ?
                scan_bits[COLUMN_COUNT-1-column_driver_outputs] : scan_bits[column_driver_outputs];
            lcd_column_pixel u_pixel (
                .pixel_i(pixel),
                .negative_image_flag_i(negative_image_flag_reg),
                .all_pixels_force_i(all_pixels_force_reg),
                .display_on_i(display_on_reg),
                .level_o(column_levels[column_driver_outputs])
            );
        end
    endgenerate

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            serial_meta_reg <= FLAG_RESET;
            serial_sync_reg <= FLAG_RESET;
        end else if (enable_i) begin
            serial_meta_reg <= serial_mode_i;
            serial_sync_reg <= serial_meta_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            display_on_reg <= FLAG_RESET;
            column_mirror_flag_reg <= FLAG_RESET;
            negative_image_flag_reg <= FLAG_RESET;
            all_pixels_force_reg <= FLAG_RESET;
            bias_ratio_bit_reg <= FLAG_RESET;
        end else begin
            if (is_display) display_on_reg <= cmd[0];
            if (is_mirror) column_mirror_flag_reg <= cmd[0];
            if (is_inverse) negative_image_flag_reg <= cmd[0];
            if (is_all_pixels) all_pixels_force_reg <= cmd[0];
            if (is_bias) bias_ratio_bit_reg <= cmd[0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            start_line_value_reg <= START_LINE_RESET;
            page_reg <= PAGE_RESET;
            column_reg <= COLUMN_RESET;
        end else begin
            if (is_soft_reset) begin
                start_line_value_reg <= START_LINE_RESET;
                page_reg <= PAGE_RESET;
            end else begin
                if (is_start) start_line_value_reg <= cmd[5:0];
                if (is_page) page_reg <= cmd[3:0];
            end
            column_reg <= column_next;
        end
    end

    // Entering again while in the mode keeps the first saved column
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            rmw_reg <= FLAG_RESET;
            saved_column_reg <= COLUMN_RESET;
        end else if (is_rmw && !rmw_reg) begin
            rmw_reg <= 1'b1;
            saved_column_reg <= column_reg;
        end else if (is_end || is_soft_reset) begin
            rmw_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            arg_state_reg <= LCD_ARG_IDLE;
        end else if (cmd_byte) begin
            arg_state_reg <= is_prefix ? LCD_ARG_SKIP : LCD_ARG_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            busy_count_reg <= BUSY_COUNT_RESET;
        end else if (is_soft_reset) begin
            busy_count_reg <= BUSY_COUNT_RESET;
        end else if (enable_i && busy) begin
            busy_count_reg <= 4'(busy_count_reg - 4'h1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            rdata_reg <= RDATA_RESET;
            rdata_valid_reg <= 1'b0;
        end else if (enable_i) begin
            rdata_valid_reg <= status_read || data_read;
            if (status_read) rdata_reg <= status_byte;
            else if (data_read) rdata_reg <= mem_read_data;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            row_reg <= ROW_RESET;
            row_out_reg <= ROW_RESET;
            columns_reg <= '0;
        end else if (enable_i) begin
            row_reg <= 6'(row_reg + 6'h01);
            row_out_reg <= row_reg;
            columns_reg <= column_levels;
        end
    end

    assign bus_rdata_o = rdata_reg;
    assign bus_rdata_valid_o = rdata_valid_reg;
    assign column_driver_outputs_o = columns_reg;
    assign active_row_o = row_out_reg;
    assign display_on_o = display_on_reg;
    assign bias_ratio_bit_o = bias_ratio_bit_reg;

    // ****************************************
    // Assertions
    // ****************************************
    logic cmd_known;
    logic [4:0] flag_bits;

    // Prefix bytes and their swallowed argument count as unknown here
    assign cmd_known = is_display || is_start || is_page || is_col_high || is_col_low ||
        is_mirror || is_bias || is_all_pixels || is_inverse || is_rmw || is_end || is_soft_reset;
    assign flag_bits = {display_on_reg, column_mirror_flag_reg, negative_image_flag_reg,
        all_pixels_force_reg, bias_ratio_bit_reg};

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence seq_end_in_mode;
        rmw_reg && is_end;
    endsequence

    // Reset flag must stand for both busy cycles
    sequence seq_busy_two;
        busy ##1 busy;
    endsequence

    AST_OFF_BLANK: assert property ($past(enable_i) && !$past(display_on_reg) |->
        column_driver_outputs_o == '0) else $error("Outputs not blank while off");
    AST_START_LOAD: assert property (is_start |=>
        start_line_value_reg == $past(cmd[5:0])) else $error("Start line not loaded");
    AST_ICON_BIT: assert property (data_read && page_reg == ICON_PAGE |=>
        bus_rdata_o[7:1] == 7'h00) else $error("Icon page read shows upper bits");
    AST_HIGH_NIBBLE: assert property (is_col_high |=>
        column_reg == {$past(cmd[3:0]), $past(column_reg[3:0])}) else $error("High nibble bad");
    AST_LOW_NIBBLE: assert property (is_col_low |=>
        column_reg == {$past(column_reg[7:4]), $past(cmd[3:0])}) else $error("Low nibble bad");
    AST_PAGE_LOAD: assert property (is_page |=> page_reg == $past(cmd[3:0])) else
        $error("Page not loaded");
    AST_READ_ADVANCE: assert property (data_read && !rmw_reg &&
        column_reg < LAST_COLUMN |=> column_reg == 8'($past(column_reg) + 8'h01)) else
        $error("Read did not advance");
    AST_WRITE_ADVANCE: assert property (data_write && column_reg < LAST_COLUMN |=>
        column_reg == 8'($past(column_reg) + 8'h01)) else $error("Write did not advance");
    AST_READ_STOP: assert property (data_read && column_reg == LAST_COLUMN |=>
        column_reg == LAST_COLUMN) else $error("Read went past last column");
    AST_WRITE_WRAP: assert property (data_write && column_reg == LAST_COLUMN |=>
        column_reg == COLUMN_RESET) else $error("Write did not wrap");
    AST_STATUS: assert property (status_read |=> bus_rdata_valid_o &&
        bus_rdata_o == {1'b0, $past(column_mirror_flag_reg), !$past(display_on_reg),
        $past(busy), 4'h0}) else $error("Status byte wrong");
    AST_SERIAL_NO_READ: assert property (strobe_live && read_write_select_i &&
        serial_sync_reg |=> !bus_rdata_valid_o) else $error("Read answered in serial mode");
    AST_RMW_HOLD: assert property (data_read && rmw_reg |=>
        $stable(column_reg) && rmw_reg) else $error("Read moved column in mode");
    AST_RMW_KEEP: assert property (rmw_reg && cmd_write && !is_end && !is_soft_reset |=>
        rmw_reg) else $error("Mode left on other command");
    AST_UNKNOWN_CMD: assert property (cmd_byte && !cmd_known |=> $stable(column_reg) &&
        $stable(page_reg) && $stable(start_line_value_reg) && $stable(flag_bits) &&
        $stable(rmw_reg)) else $error("Unknown command changed state");
    AST_BIAS_LOAD: assert property (is_bias |=> bias_ratio_bit_o == $past(cmd[0])) else
        $error("Bias bit not loaded");
    AST_RMW_RESTORE: assert property (seq_end_in_mode |=>
        column_reg == $past(saved_column_reg) && !rmw_reg) else $error("End did not restore");
    AST_SOFT_RESET: assert property (is_soft_reset |=> column_reg == COLUMN_RESET &&
        page_reg == PAGE_RESET ##0 seq_busy_two) else $error("Soft reset incomplete");

endmodule

`default_nettype wire

//--- verif/lcd_host_model.sv
`default_nettype none

module lcd_host_model (
    // Clock
    input wire logic clock_i,
    // Host byte port
    output logic bus_strobe_o,
    output logic command_data_select_o,
    output logic read_write_select_o,
    output logic [7:0] bus_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_strobe_o = 1'b0;
        command_data_select_o = 1'b0;
        read_write_select_o = 1'b0;
        bus_wdata_o = 8'h00;
    end

    // ****************************************
    // Transfers
    // ****************************************
    // Strobe stays up between calls, so back-to-back bytes need no gap
    task automatic xfer(input logic cds, input logic rw, input logic [7:0] data);
        bus_strobe_o <= 1'b1;
        command_data_select_o <= cds;
        read_write_select_o <= rw;
        bus_wdata_o <= data;
        @(posedge clock_i);
    endtask

    // Released data lines flip, so a stale byte is never mistaken for a new one
    task automatic idle();
        bus_strobe_o <= 1'b0;
        bus_wdata_o <= ~bus_wdata_o;
        @(posedge clock_i);
    endtask
endmodule

`default_nettype wire

//--- verif/testbench.sv
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lcd_pkg::*;

    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic enable_i = 1'b1;
    logic serial_mode_i = 1'b0;
    wire logic strobe;
    wire logic cds;
    wire logic rw;
    wire logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic [COLUMN_COUNT-1:0] cols;
    logic [5:0] row;
    logic disp_on;
    logic bias;
    int fails = 0;
    int num_checks = 0;
    int i;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'hd0bf;
    logic [7:0] buff[4];

    always #5 clock_i = ~clock_i;

    lcd_host_model lcd_host_model_i (.clock_i(clock_i), .bus_strobe_o(strobe),
        .command_data_select_o(cds), .read_write_select_o(rw), .bus_wdata_o(wdata));

    lcd_command_decoder lcd_command_decoder_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .enable_i(enable_i), .bus_strobe_i(strobe), .command_data_select_i(cds),
        .read_write_select_i(rw), .bus_wdata_i(wdata), .serial_mode_i(serial_mode_i),
        .bus_rdata_o(rdata), .bus_rdata_valid_o(rvalid), .column_driver_outputs_o(cols),
        .active_row_o(row), .display_on_o(disp_on), .bias_ratio_bit_o(bias));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [COLUMN_COUNT-1:0] got, input logic [COLUMN_COUNT-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        lcd_host_model_i.xfer(1'b0, 1'b0, op);
    endtask

    task automatic wr(input logic [7:0] d);
        lcd_host_model_i.xfer(1'b1, 1'b0, d);
    endtask

    // Answer is due one cycle later; the monitor pairs it with this note
    task automatic rd(input logic sel, input logic [7:0] exp);
        expq.push_back(exp);
        lcd_host_model_i.xfer(sel, 1'b1, 8'h00);
    endtask

    task automatic col(input logic [7:0] c);
        cmd({4'h0, c[3:0]});
        cmd({4'h1, c[7:4]});
    endtask

    task automatic idle(input int n);
        repeat (n) lcd_host_model_i.idle();
    endtask

    // Two edges first, so the panel already shows the last command
    task automatic pixel(input logic [5:0] r, input int column_driver_outputs, input logic val);
        idle(2);
        for (int n = 0; n < 70 && row !== r; n++) lcd_host_model_i.idle();
        if (row !== r) begin
            fails++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, row, r);
            stop_test();
        end else begin
            chk(cols & (132'h1 << column_driver_outputs), 132'(val) << column_driver_outputs);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // Read answer monitor
    // ****************************************
    always @(posedge clock_i) begin
        if (rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                fails++;
                $display("MISMATCH t=%0t got=%0h exp=%0h", $time, rdata, 8'h00);
            end else begin
                chk({124'h0, rdata}, {124'h0, expq.pop_front()});
            end
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clock_i);
        reset_n_i <= 1'b1;
        idle(3);
        rd(1'b0, 8'h20);
        cmd(8'hAF);
        rd(1'b0, 8'h00);
        cmd(8'hA1);
        rd(1'b0, 8'h40);
        cmd(8'hA0);
        cmd(8'hE3);
        cmd(8'h81);
        cmd(8'hA1);
        rd(1'b0, 8'h00);
        $display("test status done");
        cmd(8'hB2);
        col(8'h7E);
        for (i = 0; i < 4; i++) begin
            buff[i] = rnd();
            wr(buff[i]);
        end
        cmd(8'h17);
        cmd(8'h0E);
        for (i = 0; i < 4; i++) rd(1'b1, buff[i]);
        col(8'h83);
        wr(8'hA5);
        wr(8'h5A);
        col(8'h00);
        rd(1'b1, 8'h5A);
        col(8'h82);
        wr(8'h11);
        col(8'h82);
        rd(1'b1, 8'h11);
        rd(1'b1, 8'hA5);
        rd(1'b1, 8'hA5);
        cmd(8'hB8);
        col(8'h00);
        wr(8'hFF);
        col(8'h00);
        rd(1'b1, 8'h01);
        $display("test data done");
        cmd(8'hB2);
        col(8'h7E);
        cmd(8'hE0);
        rd(1'b1, buff[0]);
        rd(1'b1, buff[0]);
        wr(8'h3C);
        cmd(8'hA7);
        rd(1'b1, buff[1]);
        wr(8'hC3);
        cmd(8'hEE);
        rd(1'b1, 8'h3C);
        rd(1'b1, 8'hC3);
        cmd(8'hA6);
        $display("test rmw done");
        cmd(8'hB0);
        col(8'h00);
        wr(8'h77);
        cmd(8'hB3);
        col(8'h40);
        cmd(8'hE2);
        rd(1'b0, 8'h10);
        idle(3);
        rd(1'b1, 8'h77);
        col(8'h00);
        serial_mode_i <= 1'b1;
        idle(4);
        lcd_host_model_i.xfer(1'b0, 1'b1, 8'h00);
        lcd_host_model_i.xfer(1'b1, 1'b1, 8'h00);
        idle(1);
        serial_mode_i <= 1'b0;
        idle(4);
        rd(1'b1, 8'h77);
        $display("test reset and serial done");
        cmd(8'hB1);
        col(8'h05);
        wr(8'h01);
        cmd(8'h45);
        pixel(6'h03, 5, 1'b1);
        pixel(6'h04, 5, 1'b0);
        cmd(8'hA7);
        pixel(6'h03, 5, 1'b0);
        cmd(8'hA1);
        cmd(8'hA6);
        pixel(6'h03, COLUMN_COUNT - 1 - 5, 1'b1);
        cmd(8'hA5);
        cmd(8'hA3);
        idle(3);
        chk(cols, '1);
        chk({131'h0, bias}, 132'h1);
        cmd(8'hAE);
        cmd(8'hA2);
        idle(3);
        chk(cols, '0);
        chk({130'h0, disp_on, bias}, 132'h0);
        $display("test panel done");
        for (i = 0; i < 20 && expq.size() != 0; i++) @(posedge clock_i);
        if (expq.size() != 0) begin
            fails++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, expq.size(), 0);
        end
        stop_test();
    end
endmodule

`default_nettype wire
